// ---- shared/tmr8_pkg.sv ----
// Functional notes
// - Tick from io_tick input unless async select
// - Counter clears, counts up or down; flags
// - Source select zero stops the counter
// - Count value readable and writable anytime
// - Software count write beats clear/count
// - Three-bit waveform mode split A/B
// - Compare match sets flag next tick
// - Flags clear on service or write-one
// - Compare double buffered in PWM only
// - Software reaches buffer or active register
// - Force strobe updates output outside PWM modes only, no flag
// - Count write blocks next-tick matches
// - Output state kept across mode change
// - Output action bits apply immediately
// - Nonzero action overrides port, direction kept
// - Action zero leaves output unchanged
// - Action bits never alter counting
// - Normal mode counts up, wraps 0xFF
// - Overflow set when count becomes zero, in CTC only on a wrap from 0xFF
// - Bottom zero, max 0xFF, top per mode
// - Per-source flag and mask bit
`default_nettype none

package tmr8_pkg;
    // Register offsets
    localparam logic [3:0] ADDR_CTRL_A = 4'h0;
    localparam logic [3:0] ADDR_CTRL_B = 4'h1;
    localparam logic [3:0] ADDR_COUNT = 4'h2;
    localparam logic [3:0] ADDR_CMP_A = 4'h3;
    localparam logic [3:0] ADDR_CMP_B = 4'h4;
    localparam logic [3:0] ADDR_MASK = 4'h5;
    localparam logic [3:0] ADDR_FLAGS = 4'h6;
    localparam logic [3:0] ADDR_ASYNC = 4'h7;
    // Control A fields
    localparam int ACT_A_LSB = 6;
    localparam int ACT_B_LSB = 4;
    localparam int WGM_LO_LSB = 0;
    // Control B fields
    localparam int FORCE_A_BIT = 7;
    localparam int FORCE_B_BIT = 6;
    localparam int WGM_HI_BIT = 3;
    localparam int CS_LSB = 0;
    // Flag and mask bits
    localparam int OVF_BIT = 0;
    localparam int MFA_BIT = 1;
    localparam int MFB_BIT = 2;
    // Async register bit
    localparam int ASYNC_BIT = 3;
    // Values
    localparam logic [7:0] BOTTOM_VAL = 8'h00;
    localparam logic [7:0] MAX_VAL = 8'hFF;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [2:0] WGM_NORMAL = 3'h0;
    localparam logic [2:0] WGM_PC_MAX = 3'h1;
    localparam logic [2:0] WGM_CTC = 3'h2;
    localparam logic [2:0] WGM_FAST_MAX = 3'h3;
    localparam logic [2:0] WGM_PC_CMP = 3'h5;
    localparam logic [2:0] WGM_FAST_CMP = 3'h7;
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR = 2'h2;
    localparam logic [1:0] ACT_SET = 2'h3;
endpackage : tmr8_pkg

`default_nettype wire

// ---- core/tmr8_core.sv ----
// Implementation choices: the address map and the address-and-strobe port.
`default_nettype none

module tmr8_core
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic io_tick,
    input wire logic crystal_pin_in,
    input wire logic ovf_serviced,
    input wire logic match_a_serviced,
    input wire logic match_b_serviced,
    input wire logic [1:0] port_value,
    input wire logic [1:0] compare_pin_direction,
    output logic [1:0] pin_out,
    output logic [1:0] pin_oe_n,
    output logic [1:0] compare_out,
    output logic overflow_irq,
    output logic match_a_irq,
    output logic match_b_irq
);
    logic [7:0] ctrl_a_reg;
    logic [2:0] ctrl_b_reg;
    logic wgm_hi_reg;
    logic async_clock_select_reg;
    logic [7:0] count_value_reg;
    logic [7:0] count_value_next;
    logic [7:0] cmp_active_a_reg;
    logic [7:0] cmp_active_b_reg;
    logic [7:0] cmp_buf_a_reg;
    logic [7:0] cmp_buf_b_reg;
    logic [2:0] mask_reg;
    logic [2:0] flag_reg;
    logic [1:0] compare_out_reg;
    logic down_reg;
    logic block_reg;
    logic [7:0] rdata_reg;
    logic xtal_s1_reg;
    logic xtal_s2_reg;
    logic xtal_d_reg;
    logic io_s1_reg;
    logic io_s2_reg;
    logic [2:0] waveform_mode;
    logic [1:0] act_a;
    logic [1:0] act_b;
    logic pwm_mode;
    logic fast_mode;
    logic pc_mode;
    logic [7:0] top_val;
    logic timer_tick;
    logic wr_count;
    logic force_a;
    logic force_b;
    logic match_a;
    logic match_b;
    logic at_top;
    logic at_bottom;
    logic upd_point;
    logic ovf_set;

    // Mode field split over two control registers
    assign waveform_mode = {wgm_hi_reg, ctrl_a_reg[tmr8_pkg::WGM_LO_LSB +: 2]};
    assign act_a = ctrl_a_reg[tmr8_pkg::ACT_A_LSB +: 2];
    assign act_b = ctrl_a_reg[tmr8_pkg::ACT_B_LSB +: 2];
    assign fast_mode = (waveform_mode == tmr8_pkg::WGM_FAST_MAX) || (waveform_mode == tmr8_pkg::WGM_FAST_CMP);
    assign pc_mode = (waveform_mode == tmr8_pkg::WGM_PC_MAX) || (waveform_mode == tmr8_pkg::WGM_PC_CMP);
    assign pwm_mode = fast_mode || pc_mode;

    // Top is max or active compare A depending on mode
    assign top_val = ((waveform_mode == tmr8_pkg::WGM_CTC) || (waveform_mode == tmr8_pkg::WGM_PC_CMP)
                     || (waveform_mode == tmr8_pkg::WGM_FAST_CMP)) ? cmp_active_a_reg : tmr8_pkg::MAX_VAL;
    assign at_top = (count_value_reg == top_val);
    assign at_bottom = (count_value_reg == tmr8_pkg::BOTTOM_VAL);

    // Tick sources pass two flops; crystal edges detected after the sync pair
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            xtal_s1_reg <= 1'b0;
            xtal_s2_reg <= 1'b0;
            xtal_d_reg <= 1'b0;
            io_s1_reg <= 1'b0;
            io_s2_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            xtal_s1_reg <= crystal_pin_in;
            xtal_s2_reg <= xtal_s1_reg;
            xtal_d_reg <= xtal_s2_reg;
            io_s1_reg <= io_tick;
            io_s2_reg <= io_s1_reg;
        end
    end

    // Tick select; source field zero stops the timer
    assign timer_tick = (ctrl_b_reg != 3'h0) &&
                        (async_clock_select_reg ? (xtal_s2_reg && !xtal_d_reg) : io_s2_reg);

    assign wr_count = reg_wr && (reg_addr == tmr8_pkg::ADDR_COUNT);
    // Force strobes hold no state and work only outside PWM
    assign force_a = reg_wr && (reg_addr == tmr8_pkg::ADDR_CTRL_B) && reg_wdata[tmr8_pkg::FORCE_A_BIT] && !pwm_mode;
    assign force_b = reg_wr && (reg_addr == tmr8_pkg::ADDR_CTRL_B) && reg_wdata[tmr8_pkg::FORCE_B_BIT] && !pwm_mode;

    // Matches counted only on a tick and not right after a count write
    assign match_a = timer_tick && !block_reg && (count_value_reg == cmp_active_a_reg);
    assign match_b = timer_tick && !block_reg && (count_value_reg == cmp_active_b_reg);

    // Buffer transfer at top for fast PWM, at bottom for phase correct
    assign upd_point = timer_tick && ((fast_mode && at_top) || (pc_mode && at_bottom));

    // Next count; action bits play no part here
    always_comb
    begin
        count_value_next = count_value_reg;
        if (waveform_mode == tmr8_pkg::WGM_NORMAL)
            count_value_next = 8'(count_value_reg + 8'h01);
        else if (pc_mode)
        begin
            if (down_reg)
                count_value_next = at_bottom ? 8'h01 : 8'(count_value_reg - 8'h01);
            else
                count_value_next = at_top ? 8'(count_value_reg - 8'h01) : 8'(count_value_reg + 8'h01);
        end
        else
            count_value_next = at_top ? tmr8_pkg::BOTTOM_VAL : 8'(count_value_reg + 8'h01);
    end

    // Overflow condition per mode
    assign ovf_set = timer_tick && (pc_mode ? (down_reg && count_value_next == tmr8_pkg::BOTTOM_VAL)
                     : fast_mode ? at_top : (count_value_reg == tmr8_pkg::MAX_VAL));

    // Counter and direction; software write wins
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_value_reg <= tmr8_pkg::RESET_BYTE;
            down_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            if (wr_count)
                count_value_reg <= reg_wdata;
            else if (timer_tick)
                count_value_reg <= count_value_next;
            if (!pc_mode)
                down_reg <= 1'b0;
            else if (timer_tick && at_top)
                down_reg <= 1'b1;
            else if (timer_tick && at_bottom)
                down_reg <= 1'b0;
        end
    end

    // Blocking window lasts until the next tick, even when stopped
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            block_reg <= 1'b0;
        else if (clk_en)
        begin
            if (wr_count)
                block_reg <= 1'b1;
            else if (timer_tick)
                block_reg <= 1'b0;
        end
    end

    // Control and mask registers; action bits used directly
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_a_reg <= tmr8_pkg::RESET_BYTE;
            ctrl_b_reg <= 3'h0;
            wgm_hi_reg <= 1'b0;
            async_clock_select_reg <= 1'b0;
            mask_reg <= 3'h0;
        end
        else if (clk_en && reg_wr)
        begin
            case (reg_addr)
                tmr8_pkg::ADDR_CTRL_A: ctrl_a_reg <= reg_wdata;
                tmr8_pkg::ADDR_CTRL_B:
                begin
                    ctrl_b_reg <= reg_wdata[tmr8_pkg::CS_LSB +: 3];
                    wgm_hi_reg <= reg_wdata[tmr8_pkg::WGM_HI_BIT];
                end
                tmr8_pkg::ADDR_ASYNC: async_clock_select_reg <= reg_wdata[tmr8_pkg::ASYNC_BIT];
                tmr8_pkg::ADDR_MASK: mask_reg <= reg_wdata[2:0];
                default: ;
            endcase
        end
    end

    // Compare registers: buffer in PWM, direct otherwise
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cmp_active_a_reg <= tmr8_pkg::RESET_BYTE;
            cmp_active_b_reg <= tmr8_pkg::RESET_BYTE;
            cmp_buf_a_reg <= tmr8_pkg::RESET_BYTE;
            cmp_buf_b_reg <= tmr8_pkg::RESET_BYTE;
        end
        else if (clk_en)
        begin
            if (reg_wr && reg_addr == tmr8_pkg::ADDR_CMP_A)
            begin
                cmp_buf_a_reg <= reg_wdata;
                if (!pwm_mode)
                    cmp_active_a_reg <= reg_wdata;
            end
            if (reg_wr && reg_addr == tmr8_pkg::ADDR_CMP_B)
            begin
                cmp_buf_b_reg <= reg_wdata;
                if (!pwm_mode)
                    cmp_active_b_reg <= reg_wdata;
            end
            if (pwm_mode && upd_point)
            begin
                cmp_active_a_reg <= cmp_buf_a_reg;
                cmp_active_b_reg <= cmp_buf_b_reg;
            end
        end
    end

    // Sticky flags: hardware set wins over write-one or service clear
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            flag_reg <= 3'h0;
        else if (clk_en)
        begin
            for (int i = 0; i < 3; i++)
            begin
                if ((reg_wr && reg_addr == tmr8_pkg::ADDR_FLAGS && reg_wdata[i])
                    || (i == tmr8_pkg::OVF_BIT && ovf_serviced)
                    || (i == tmr8_pkg::MFA_BIT && match_a_serviced)
                    || (i == tmr8_pkg::MFB_BIT && match_b_serviced))
                    flag_reg[i] <= 1'b0;
            end
            if (ovf_set)
                flag_reg[tmr8_pkg::OVF_BIT] <= 1'b1;
            if (match_a)
                flag_reg[tmr8_pkg::MFA_BIT] <= 1'b1;
            if (match_b)
                flag_reg[tmr8_pkg::MFB_BIT] <= 1'b1;
        end
    end

    // Output action for one channel on a match or forced match
    function automatic logic cmp_next(input logic cur, input logic [1:0] act, input logic pwm,
                                      input logic down, input logic hit, input logic at_reload);
        logic r;
        r = cur;
        if (act != tmr8_pkg::ACT_NONE)
        begin
            if (!pwm)
            begin
                if (hit)
                    r = (act == tmr8_pkg::ACT_TOGGLE) ? !cur : (act == tmr8_pkg::ACT_SET);
            end
            else if (act[1])
            begin
                // Inverted when low action bit set
                if (hit)
                    r = act[0] ^ down ^ 1'b0;
                else if (at_reload)
                    r = !act[0];
            end
            else if (hit)
                r = !cur;
        end
        return r;
    endfunction : cmp_next

    // Output state registers; never reset by a mode change
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            compare_out_reg <= 2'h0;
        else if (clk_en)
        begin
            compare_out_reg[0] <= cmp_next(compare_out_reg[0], act_a, pwm_mode, down_reg,
                                           match_a || force_a, timer_tick && fast_mode && at_top);
            compare_out_reg[1] <= cmp_next(compare_out_reg[1], act_b, pwm_mode, down_reg,
                                           match_b || force_b, timer_tick && fast_mode && at_top);
        end
    end

    // Read data registered one cycle later; force bits read zero
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            rdata_reg <= tmr8_pkg::RESET_BYTE;
        else if (clk_en)
        begin
            if (reg_rd)
            begin
                case (reg_addr)
                    tmr8_pkg::ADDR_CTRL_A: rdata_reg <= ctrl_a_reg;
                    tmr8_pkg::ADDR_CTRL_B: rdata_reg <= {4'h0, wgm_hi_reg, ctrl_b_reg};
                    tmr8_pkg::ADDR_COUNT: rdata_reg <= count_value_reg;
                    tmr8_pkg::ADDR_CMP_A: rdata_reg <= pwm_mode ? cmp_buf_a_reg : cmp_active_a_reg;
                    tmr8_pkg::ADDR_CMP_B: rdata_reg <= pwm_mode ? cmp_buf_b_reg : cmp_active_b_reg;
                    tmr8_pkg::ADDR_MASK: rdata_reg <= {5'h00, mask_reg};
                    tmr8_pkg::ADDR_FLAGS: rdata_reg <= {5'h00, flag_reg};
                    tmr8_pkg::ADDR_ASYNC: rdata_reg <= {4'h0, async_clock_select_reg, 3'h0};
                    default: rdata_reg <= tmr8_pkg::RESET_BYTE;
                endcase
            end
            else
                rdata_reg <= tmr8_pkg::RESET_BYTE;
        end
    end

    assign reg_rdata = rdata_reg;
    assign compare_out = compare_out_reg;

    // Pin override by compare output; direction stays with port
    assign pin_out[0] = (act_a != tmr8_pkg::ACT_NONE) ? compare_out_reg[0] : port_value[0];
    assign pin_out[1] = (act_b != tmr8_pkg::ACT_NONE) ? compare_out_reg[1] : port_value[1];
    assign pin_oe_n = ~compare_pin_direction;

    // Masked interrupt requests
    assign overflow_irq = flag_reg[tmr8_pkg::OVF_BIT] && mask_reg[tmr8_pkg::OVF_BIT];
    assign match_a_irq = flag_reg[tmr8_pkg::MFA_BIT] && mask_reg[tmr8_pkg::MFA_BIT];
    assign match_b_irq = flag_reg[tmr8_pkg::MFB_BIT] && mask_reg[tmr8_pkg::MFB_BIT];
endmodule : tmr8_core

`default_nettype wire

// ---- bench/tmr8_monitor.sv ----
`default_nettype none

module tmr8_monitor
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic ovf_serviced,
    input wire logic match_a_serviced,
    input wire logic match_b_serviced,
    input wire logic [1:0] port_value,
    input wire logic [1:0] compare_pin_direction,
    input wire logic [1:0] pin_out,
    input wire logic [1:0] pin_oe_n,
    input wire logic [1:0] compare_out,
    input wire logic overflow_irq,
    input wire logic match_a_irq,
    input wire logic match_b_irq
);
    // One clock domain, so clock and reset are given once
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    a_read_slot_only: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data present outside the read slot");
    a_unmapped_reads_zero: assert property ($past(reg_rd) && $past(reg_addr) > 4'h7 |-> reg_rdata == 8'h00)
        else $error("unmapped address returned data");
    a_force_reads_zero: assert property ($past(reg_rd) && $past(reg_addr) == tmr8_pkg::ADDR_CTRL_B
        |-> reg_rdata[7:6] == 2'h0) else $error("force bits read back nonzero");
    a_pin_dir_kept: assert property (pin_oe_n == ~compare_pin_direction)
        else $error("pin enable does not follow the direction bit");
    // Each pin bit is either the compare state or the plain port bit, never a third value
    a_pin_source_legal: assert property (((pin_out ^ compare_out) & (pin_out ^ port_value)) == 2'b00)
        else $error("pin carries neither compare state nor port value");
    a_ovf_clear_cause: assert property ($fell(overflow_irq) |-> $past(ovf_serviced) || $past(reg_wr))
        else $error("overflow request dropped without service or write");
    a_match_a_clear: assert property ($fell(match_a_irq) |-> $past(match_a_serviced) || $past(reg_wr))
        else $error("channel A request dropped without service or write");
    a_match_b_clear: assert property ($fell(match_b_irq) |-> $past(match_b_serviced) || $past(reg_wr))
        else $error("channel B request dropped without service or write");
    a_mask_off_quiet: assert property (reg_wr && reg_addr == tmr8_pkg::ADDR_MASK && reg_wdata[2:0] == 3'h0
        |=> !overflow_irq && !match_a_irq && !match_b_irq) else $error("masked source still requests");
endmodule : tmr8_monitor

`default_nettype wire

// ---- bench/tmr8_port_pins.sv ----
`default_nettype none

module tmr8_port_pins
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic set_en,
    input wire logic [1:0] set_val,
    input wire logic [1:0] set_dir,
    input wire logic [1:0] pin_out,
    input wire logic [1:0] pin_oe_n,
    output logic [1:0] port_value,
    output logic [1:0] compare_pin_direction,
    output logic [1:0] pad
);
    // Port bits as software leaves them; reset turns every pin into an input
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            port_value <= 2'h0;
            compare_pin_direction <= 2'h0;
        end
        else if (set_en)
        begin
            port_value <= set_val;
            compare_pin_direction <= set_dir;
        end
    end

    // Pull-up wins whenever the timer side leaves the pad undriven
    assign pad = (pin_out & ~pin_oe_n) | pin_oe_n;
endmodule : tmr8_port_pins

`default_nettype wire

// ---- bench/tb_tmr8_core.sv ----
`default_nettype none

module tb_tmr8_core;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic [7:0] cb_hi = 8'h00;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic io_tick = 1'b0;
    logic crystal_pin_in = 1'b0;
    logic [2:0] svc = 3'h0;
    logic set_en = 1'b0;
    logic [1:0] set_val = 2'h0;
    logic [1:0] set_dir = 2'h0;
    logic [7:0] reg_rdata;
    logic [1:0] port_value, compare_pin_direction, pin_out, pin_oe_n, compare_out, pad;
    logic overflow_irq, match_a_irq, match_b_irq;
    logic [7:0] r;
    logic exp_oc;
    logic [1:0] acts [5] = '{tmr8_pkg::ACT_SET, tmr8_pkg::ACT_CLEAR, tmr8_pkg::ACT_TOGGLE,
        tmr8_pkg::ACT_NONE, tmr8_pkg::ACT_TOGGLE};
    int err_count = 0;
    int n_checks = 0;
    int cycles = 0;

    tmr8_core tmr8_core_i (.sys_clk, .rst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .io_tick, .crystal_pin_in, .ovf_serviced(svc[0]), .match_a_serviced(svc[1]),
        .match_b_serviced(svc[2]), .port_value, .compare_pin_direction, .pin_out, .pin_oe_n,
        .compare_out, .overflow_irq, .match_a_irq, .match_b_irq);
    tmr8_port_pins tmr8_port_pins_i (.sys_clk, .rst_n, .set_en, .set_val, .set_dir, .pin_out,
        .pin_oe_n, .port_value, .compare_pin_direction, .pad);

    initial
    begin
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic results();
        $display("Checks %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : results

    // Cut a hang short well past the few hundred cycles the sequence needs
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            results();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe, so take them just after that edge
    task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask : rdchk

    task automatic settle();
        repeat (2) @(posedge sys_clk);
        #1;
    endtask : settle

    // Each high cycle of the tick input is one tick; wait out the two-flop sync afterwards
    // The mode high bit in cb_hi survives both control writes
    task automatic run(input int n);
        wr(tmr8_pkg::ADDR_CTRL_B, cb_hi | 8'h01);
        @(posedge sys_clk);
        io_tick <= 1'b1;
        repeat (n) @(posedge sys_clk);
        io_tick <= 1'b0;
        repeat (4) @(posedge sys_clk);
        wr(tmr8_pkg::ADDR_CTRL_B, cb_hi);
    endtask : run

    task automatic pins(input logic [1:0] v, input logic [1:0] d);
        @(posedge sys_clk);
        set_en <= 1'b1;
        set_val <= v;
        set_dir <= d;
        @(posedge sys_clk);
        set_en <= 1'b0;
    endtask : pins

    function automatic logic nxt(input logic [1:0] act, input logic cur);
        case (act)
            tmr8_pkg::ACT_SET: return 1'b1;
            tmr8_pkg::ACT_CLEAR: return 1'b0;
            tmr8_pkg::ACT_TOGGLE: return ~cur;
            default: return cur;
        endcase
    endfunction : nxt

    initial
    begin
        void'($urandom(32'h0d6d_710a));
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        pins(2'($urandom), 2'($urandom));
        for (int a = 0; a < 16; a++)
            rdchk(4'(a), tmr8_pkg::RESET_BYTE);
        // Random counts, then ticks with no source selected must leave the count alone
        repeat (4)
        begin
            r = 8'($urandom);
            wr(tmr8_pkg::ADDR_COUNT, r);
            rdchk(tmr8_pkg::ADDR_COUNT, r);
            wr(4'h8 + 4'($urandom % 8), r);
            rdchk(4'hF, 8'h00);
        end
        @(posedge sys_clk);
        io_tick <= 1'b1;
        repeat (3) @(posedge sys_clk);
        io_tick <= 1'b0;
        repeat (4) @(posedge sys_clk);
        rdchk(tmr8_pkg::ADDR_COUNT, r);
        // Wrap through the top; both compare values are still zero
        wr(tmr8_pkg::ADDR_MASK, 8'h07);
        wr(tmr8_pkg::ADDR_COUNT, 8'hFC);
        run(6);
        rdchk(tmr8_pkg::ADDR_COUNT, 8'h02);
        chk({7'h0, overflow_irq}, 8'h01);
        rdchk(tmr8_pkg::ADDR_FLAGS, 8'h07);
        @(posedge sys_clk);
        svc <= 3'b001;
        @(posedge sys_clk);
        svc <= 3'b000;
        settle();
        chk({7'h0, overflow_irq}, 8'h00);
        wr(tmr8_pkg::ADDR_FLAGS, 8'h06);
        rdchk(tmr8_pkg::ADDR_FLAGS, 8'h00);
        // Crystal source: the plain tick input must be ignored
        wr(tmr8_pkg::ADDR_ASYNC, 8'h08);
        wr(tmr8_pkg::ADDR_COUNT, 8'h00);
        wr(tmr8_pkg::ADDR_CTRL_B, 8'h01);
        repeat (5)
        begin
            @(posedge sys_clk);
            crystal_pin_in <= 1'b1;
            io_tick <= 1'b1;
            repeat (3) @(posedge sys_clk);
            crystal_pin_in <= 1'b0;
            repeat (3) @(posedge sys_clk);
        end
        io_tick <= 1'b0;
        repeat (4) @(posedge sys_clk);
        wr(tmr8_pkg::ADDR_CTRL_B, 8'h00);
        rdchk(tmr8_pkg::ADDR_COUNT, 8'h05);
        rdchk(tmr8_pkg::ADDR_FLAGS, 8'h00);
        wr(tmr8_pkg::ADDR_ASYNC, 8'h00);
        // Toggle on match, seen on the pad while the pin is an output
        wr(tmr8_pkg::ADDR_CMP_A, 8'h12);
        rdchk(tmr8_pkg::ADDR_CMP_A, 8'h12);
        wr(tmr8_pkg::ADDR_CTRL_A, {tmr8_pkg::ACT_TOGGLE, 6'h00});
        wr(tmr8_pkg::ADDR_COUNT, 8'h10);
        pins(2'b00, 2'b11);
        run(3);
        rdchk(tmr8_pkg::ADDR_COUNT, 8'h13);
        rdchk(tmr8_pkg::ADDR_FLAGS, 8'h02);
        chk({6'h0, compare_out}, 8'h01);
        chk({7'h0, match_a_irq}, 8'h01);
        chk({6'h0, pad}, 8'h01);
        pins(2'b00, 2'b00);
        settle();
        chk({6'h0, pad}, 8'h03);
        wr(tmr8_pkg::ADDR_FLAGS, 8'h02);
        settle();
        chk({7'h0, match_a_irq}, 8'h00);
        // A count write hides the match on the very next tick only
        // Channel B drives no waveform, so a count equal to its compare is allowed
        wr(tmr8_pkg::ADDR_CMP_B, 8'h40);
        wr(tmr8_pkg::ADDR_COUNT, 8'h40);
        run(1);
        rdchk(tmr8_pkg::ADDR_COUNT, 8'h41);
        rdchk(tmr8_pkg::ADDR_FLAGS, 8'h00);
        wr(tmr8_pkg::ADDR_COUNT, 8'h3F);
        run(2);
        rdchk(tmr8_pkg::ADDR_FLAGS, 8'h04);
        wr(tmr8_pkg::ADDR_FLAGS, 8'h04);
        // Every output action through the force strobe
        exp_oc = 1'b1;
        foreach (acts[i])
        begin
            wr(tmr8_pkg::ADDR_CTRL_A, {acts[i], 6'h00});
            wr(tmr8_pkg::ADDR_CTRL_B, 8'h80);
            exp_oc = nxt(acts[i], exp_oc);
            settle();
            chk({7'h0, compare_out[0]}, {7'h0, exp_oc});
        end
        rdchk(tmr8_pkg::ADDR_COUNT, 8'h41);
        rdchk(tmr8_pkg::ADDR_FLAGS, 8'h00);
        rdchk(tmr8_pkg::ADDR_CTRL_B, 8'h00);
        // Mode change keeps the state; force is ignored in a PWM mode
        wr(tmr8_pkg::ADDR_CTRL_A, {tmr8_pkg::ACT_TOGGLE, 4'h0, tmr8_pkg::WGM_FAST_MAX[1:0]});
        wr(tmr8_pkg::ADDR_CTRL_B, 8'h80);
        settle();
        chk({7'h0, compare_out[0]}, {7'h0, exp_oc});
        wr(tmr8_pkg::ADDR_CTRL_A, 8'h00);
        settle();
        chk({7'h0, compare_out[0]}, {7'h0, exp_oc});
        // Fast PWM with top at compare A; a new compare waits in the buffer until top
        cb_hi = 8'h08;
        wr(tmr8_pkg::ADDR_CTRL_A, 8'h03);
        wr(tmr8_pkg::ADDR_CMP_A, 8'h05);
        rdchk(tmr8_pkg::ADDR_CMP_A, 8'h05);
        wr(tmr8_pkg::ADDR_COUNT, 8'h10);
        run(4);
        rdchk(tmr8_pkg::ADDR_COUNT, 8'h01);
        rdchk(tmr8_pkg::ADDR_FLAGS, 8'h03);
        rdchk(tmr8_pkg::ADDR_CTRL_B, 8'h08);
        run(6);
        rdchk(tmr8_pkg::ADDR_COUNT, 8'h01);
        chk({7'h0, compare_out[0]}, {7'h0, exp_oc});
        // A low clock enable drops a count write
        @(posedge sys_clk);
        clk_en <= 1'b0;
        wr(tmr8_pkg::ADDR_COUNT, 8'h77);
        clk_en <= 1'b1;
        rdchk(tmr8_pkg::ADDR_COUNT, 8'h01);
        results();
    end
endmodule : tb_tmr8_core

bind tmr8_core tmr8_monitor tmr8_monitor_i (.sys_clk, .rst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .ovf_serviced, .match_a_serviced, .match_b_serviced, .port_value,
    .compare_pin_direction, .pin_out, .pin_oe_n, .compare_out, .overflow_irq, .match_a_irq, .match_b_irq);

`default_nettype wire
